/* File: pmx_board.sv */
module pmx_board (
  input wire logic aclk,
  input wire logic [3:0][31:0] board_pads,
  input wire logic board_hr_n,
  input wire logic [3:0][31:0] pad_out,
  input wire logic [3:0][31:0] pad_drive_n,
  input wire logic hard_reset_io_out,
  input wire logic hard_reset_io_oe_n,
  output logic [3:0][31:0] pad_in,
  output logic [3:0][31:0] periph_out,
  output logic [3:0][31:0] periph_oe,
  output logic clock_output_pin,
  output logic hard_reset_io_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] tick_q = 2'h0;
  always @(posedge aclk)
  begin
    tick_q <= tick_q + 2'h1;
  end
  // Peripheral pattern flips every cycle
  assign periph_out = {4{32'hA5C3_0F69 ^ {32{tick_q[0]}}}};
  assign periph_oe = {4{32'hFFFF_FFFF}};
  assign clock_output_pin = tick_q[1];
  // Device drive wins over board level
  assign pad_in = (board_pads & pad_drive_n) | (pad_out & ~pad_drive_n);
  assign hard_reset_io_in = board_hr_n & (hard_reset_io_oe_n | hard_reset_io_out);
endmodule // pmx_board

/* File: pmx_map.svh */
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH

// Register byte offsets
`define PMX_OFF_OWNER_BASE 8'h00
`define PMX_OFF_DIR_BASE 8'h10
`define PMX_OFF_DOUT_BASE 8'h20
`define PMX_OFF_DIN_BASE 8'h30
`define PMX_OFF_IRQ_EN 8'h40
`define PMX_OFF_CHIP_CFG 8'h44
`define PMX_OFF_STRAP 8'h48
`define PMX_OFF_ISTAT 8'h4C
`define PMX_OFF_IMASK 8'h50

// Chip configuration fields
`define PMX_CFG_PORT_A_ALT_SELECT_BIT 0
`define PMX_CFG_PORT_D_ALT_SELECT_BIT 1
`define PMX_CFG_MASK 32'h0000_0003

// Reset values
`define PMX_RST_WORD 32'h0000_0000

// Lines that may be general input or output, per port A..D
`define PMX_GP_MASK_A 32'h3FFB_FFFF
`define PMX_GP_MASK_B 32'h0000_0800
`define PMX_GP_MASK_C 32'h0000_C8FF
`define PMX_GP_MASK_D 32'h0000_01F0
// Lines with a peripheral function
`define PMX_HW_MASK_A 32'h0003_FFC0
`define PMX_HW_MASK_B 32'h0000_7FFF
`define PMX_HW_MASK_C 32'h0000_FFFF
`define PMX_HW_MASK_D 32'h0000_01F8
// Lines with the alternate clock output
`define PMX_ALT_MASK_A 32'h0002_0000
`define PMX_ALT_MASK_D 32'h0000_0008
// Maskable interrupt capable port A lines
`define PMX_IRQ_MASK_A 32'h3FFB_FDBF
// Non-maskable interrupt line on port A
`define PMX_NMI_BIT 18
// Strap lines per port, captured at power-on reset release
`define PMX_STRAP_MASK_A 32'h0001_0000
`define PMX_STRAP_MASK_C 32'h0000_C000
`define PMX_STRAP_MASK_D 32'h0000_0188

`define PMX_RESP_OKAY 2'b00
`define PMX_RESP_SLVERR 2'b10

`endif

/* File: pmx_pkg.sv */
package pmx_pkg;

  typedef logic [3:0][31:0] pmx_word4_t;

  typedef struct packed {
    pmx_word4_t owner;
    pmx_word4_t dir;
    pmx_word4_t dout;
  } pmx_port_cfg_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } pmx_rd_t;

endpackage

/* File: pmx_props.sv */
`include "pmx_map.svh"
module pmx_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [3:0][31:0] pad_in,
  input wire logic [3:0][31:0] pad_drive_n,
  input wire logic [31:0] irq_request,
  input wire logic nmi_n,
  input wire logic [3:0][31:0] strap_value,
  input wire logic power_on_reset_in_n,
  input wire logic hard_reset_io_in,
  input wire logic hard_reset_io_oe_n,
  input wire logic device_reset_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_por_low;
    !power_on_reset_in_n [*4];
  endsequence
  sequence s_por_high;
    power_on_reset_in_n [*6];
  endsequence
  chk_por_hold: assert property (s_por_low |-> !device_reset_n)
    else $error("reset not held in power-on");
  chk_hr_reset: assert property (!hard_reset_io_in [*4] |-> !device_reset_n)
    else $error("hard reset ignored");
  chk_hr_drive: assert property (s_por_low |-> !hard_reset_io_oe_n)
    else $error("hard reset not driven");
  chk_hr_free: assert property (s_por_high |-> hard_reset_io_oe_n)
    else $error("hard reset driven late");
  chk_strap_hold: assert property (s_por_high |-> $stable(strap_value))
    else $error("strap changed");
  chk_nmi_sync: assert property ($stable(pad_in[0][18]) [*3] |-> nmi_n == pad_in[0][18])
    else $error("nmi level wrong");
  chk_rsvd_float: assert property (pad_drive_n[0][18] && &pad_drive_n[1][31:15])
    else $error("reserved pad driven");
  chk_irq_lines: assert property ((irq_request & ~`PMX_IRQ_MASK_A) == 32'h0)
    else $error("request on reserved line");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // pmx_props

bind pmx_top pmx_props i_pmx_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pad_in, .pad_drive_n, .irq_request, .nmi_n,
  .strap_value, .power_on_reset_in_n, .hard_reset_io_in, .hard_reset_io_oe_n, .device_reset_n);

/* File: pmx_top.sv */
`include "pmx_map.svh"
// Function
// [R1] A software-owned input line with interrupt enable clear is a general input, the reset state.
// [R2] A software-owned port A input with interrupt enable set feeds its interrupt request.
// [R3] A peripheral-owned line with both alternate selects clear carries its primary function.
// [R4] Strap levels are captured only when power-on reset is released, never otherwise.
// [R5] While power-on reset is asserted the device is held in reset.
// [R6] The hard reset pin is open-drain both ways and either side asserting it resets the device.
// [R7] Peripheral ownership hands the pad to the peripheral and disables the port A interrupt.
// [R8] A software-owned output line is a general output and disables the port A interrupt.
// [R9] Alternate clock output appears only on peripheral-owned lines with the alternate select set.
// [R10] The non-maskable interrupt line serves only as that input.
// [R11] Reserved configurations leave the pad undriven and read as zero.
module pmx_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0][31:0] pad_in,
  output logic [3:0][31:0] pad_out,
  output logic [3:0][31:0] pad_drive_n,
  input wire logic [3:0][31:0] periph_out,
  input wire logic [3:0][31:0] periph_oe,
  output logic [3:0][31:0] periph_in,
  input wire logic clock_output_pin,
  output logic [31:0] irq_request,
  output logic nmi_n,
  output logic [3:0][31:0] strap_value,
  input wire logic power_on_reset_in_n,
  input wire logic hard_reset_io_in,
  output logic hard_reset_io_out,
  output logic hard_reset_io_oe_n,
  output logic device_reset_n,
  output logic irq
);

  localparam pmx_pkg::pmx_word4_t GP_MASK =
    {`PMX_GP_MASK_D, `PMX_GP_MASK_C, `PMX_GP_MASK_B, `PMX_GP_MASK_A};
  localparam pmx_pkg::pmx_word4_t HW_MASK =
    {`PMX_HW_MASK_D, `PMX_HW_MASK_C, `PMX_HW_MASK_B, `PMX_HW_MASK_A};
  localparam pmx_pkg::pmx_word4_t STRAP_MASK =
    {`PMX_STRAP_MASK_D, `PMX_STRAP_MASK_C, 32'h0000_0000, `PMX_STRAP_MASK_A};

  pmx_pkg::pmx_port_cfg_t cfg_q;
  logic [31:0] irq_en_q, chip_cfg_q, istat_q, imask_q;
  pmx_pkg::pmx_word4_t pad_s1_q, pad_s2_q;
  logic [31:0] pad_a_prev_q;
  logic por_s1_q, por_s2_q, por_s3_q, hr_s1_q, hr_s2_q;
  logic dev_rst;
  logic [7:0] aw_addr_q, ar_addr;
  logic [31:0] w_data_q, wmask;
  logic [3:0] w_strb_q;
  logic aw_full_q, w_full_q, do_write, wr_hit, rd_take, istat_rd;
  logic [31:0] irq_en_eff, irq_fall;
  pmx_pkg::pmx_rd_t rd;

  // Pad, reset and hard reset pins cross in through two flip-flops
  always_ff @(posedge aclk)
  begin
    pad_s1_q <= pad_in;
    pad_s2_q <= pad_s1_q;
    por_s1_q <= power_on_reset_in_n;
    por_s2_q <= por_s1_q;
    por_s3_q <= por_s2_q;
    hr_s1_q <= hard_reset_io_in;
    hr_s2_q <= hr_s1_q;
  end

  // [R5] held in reset
  // [R6] either side resets
  assign dev_rst = !aresetn || !por_s2_q || !hr_s2_q;
  assign device_reset_n = !dev_rst;

  // [R6] open-drain, drive low only
  assign hard_reset_io_out = 1'b0;
  assign hard_reset_io_oe_n = por_s2_q;

  // [R4] capture on power-on release only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      strap_value <= '0;
    else if (por_s2_q && !por_s3_q)
      strap_value <= pad_s2_q & STRAP_MASK;
  end

  // AXI write channel capture
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_hit = (aw_addr_q < `PMX_OFF_DIN_BASE) || (aw_addr_q == `PMX_OFF_IRQ_EN)
    || (aw_addr_q == `PMX_OFF_CHIP_CFG) || (aw_addr_q == `PMX_OFF_IMASK);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= `PMX_RST_WORD;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMX_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `PMX_RESP_OKAY : `PMX_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Port configuration registers
  always_ff @(posedge aclk)
  begin
    if (dev_rst)
    begin
      // [R1] all general-purpose lines software inputs
      cfg_q <= '0;
      irq_en_q <= `PMX_RST_WORD;
      chip_cfg_q <= `PMX_RST_WORD;
      imask_q <= `PMX_RST_WORD;
    end
    else if (do_write)
    begin
      // [R11] reserved bits never stored, except in the interrupt mask
      if (aw_addr_q < `PMX_OFF_DIR_BASE)
        cfg_q.owner[aw_addr_q[3:2]] <= ((cfg_q.owner[aw_addr_q[3:2]] & ~wmask)
          | (w_data_q & wmask)) & HW_MASK[aw_addr_q[3:2]];
      else if (aw_addr_q < `PMX_OFF_DOUT_BASE)
        cfg_q.dir[aw_addr_q[3:2]] <= ((cfg_q.dir[aw_addr_q[3:2]] & ~wmask)
          | (w_data_q & wmask)) & GP_MASK[aw_addr_q[3:2]];
      else if (aw_addr_q < `PMX_OFF_DIN_BASE)
        cfg_q.dout[aw_addr_q[3:2]] <= ((cfg_q.dout[aw_addr_q[3:2]] & ~wmask)
          | (w_data_q & wmask)) & GP_MASK[aw_addr_q[3:2]];
      else if (aw_addr_q == `PMX_OFF_IRQ_EN)
        irq_en_q <= ((irq_en_q & ~wmask) | (w_data_q & wmask)) & `PMX_IRQ_MASK_A;
      else if (aw_addr_q == `PMX_OFF_CHIP_CFG)
        chip_cfg_q <= ((chip_cfg_q & ~wmask) | (w_data_q & wmask)) & `PMX_CFG_MASK;
      else if (aw_addr_q == `PMX_OFF_IMASK)
        imask_q <= (imask_q & ~wmask) | (w_data_q & wmask);
    end
  end

  // Pad multiplexing per port
  generate
    for (genvar p = 0; p < 4; p++)
    begin : g_port
      logic [31:0] sw_own, hw_own, general_output, alt, prim, alt_mask;
      logic alt_sel;
      assign alt_mask = (p == 0) ? `PMX_ALT_MASK_A : ((p == 3) ? `PMX_ALT_MASK_D : 32'h0);
      assign alt_sel = (p == 0) ? chip_cfg_q[`PMX_CFG_PORT_A_ALT_SELECT_BIT]
        : ((p == 3) ? chip_cfg_q[`PMX_CFG_PORT_D_ALT_SELECT_BIT] : 1'b0);
      assign sw_own = ~cfg_q.owner[p] & GP_MASK[p];
      assign hw_own = cfg_q.owner[p] & HW_MASK[p];
      // [R8] general output
      assign general_output = sw_own & cfg_q.dir[p];
      // [R9] alternate clock output
      assign alt = hw_own & alt_mask & {32{alt_sel}};
      // [R3] primary peripheral function
      // [R7] pad handed to peripheral
      assign prim = hw_own & ~alt;
      assign pad_out[p] = (general_output & cfg_q.dout[p]) | (alt & {32{clock_output_pin}})
        | (prim & periph_out[p]);
      // [R11] reserved lines stay undriven
      assign pad_drive_n[p] = ~(general_output | alt | (prim & periph_oe[p]));
      assign periph_in[p] = pad_s2_q[p] & prim;
    end
  endgenerate

  // [R2] interrupt routing
  // [R7] [R8] interrupt dropped when not a software input
  assign irq_en_eff = irq_en_q & ~cfg_q.owner[0] & ~cfg_q.dir[0] & `PMX_IRQ_MASK_A;
  assign irq_request = irq_en_eff & ~pad_s2_q[0];
  // [R10] dedicated non-maskable input
  assign nmi_n = pad_s2_q[0][`PMX_NMI_BIT];

  // Falling edges of active-low requests, plus the non-maskable line
  always_ff @(posedge aclk)
  begin
    pad_a_prev_q <= pad_s2_q[0];
  end
  assign irq_fall = pad_a_prev_q & ~pad_s2_q[0]
    & (irq_en_eff | (32'h1 << `PMX_NMI_BIT));

  // Sticky status, read clears, set wins
  always_ff @(posedge aclk)
  begin
    if (dev_rst)
      istat_q <= `PMX_RST_WORD;
    else if (istat_rd)
      istat_q <= irq_fall;
    else
      istat_q <= istat_q | irq_fall;
  end
  assign irq = |(istat_q & imask_q);

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign ar_addr = {s_axi_araddr[7:2], 2'b00};
  assign istat_rd = rd_take && (ar_addr == `PMX_OFF_ISTAT);

  always_comb
  begin
    rd.resp = `PMX_RESP_OKAY;
    rd.data = `PMX_RST_WORD;
    if (ar_addr < `PMX_OFF_DIR_BASE)
      rd.data = cfg_q.owner[ar_addr[3:2]];
    else if (ar_addr < `PMX_OFF_DOUT_BASE)
      rd.data = cfg_q.dir[ar_addr[3:2]];
    else if (ar_addr < `PMX_OFF_DIN_BASE)
      rd.data = cfg_q.dout[ar_addr[3:2]];
    // [R11] reserved lines read zero
    else if (ar_addr < `PMX_OFF_IRQ_EN)
      rd.data = pad_s2_q[ar_addr[3:2]] & GP_MASK[ar_addr[3:2]];
    else if (ar_addr == `PMX_OFF_IRQ_EN)
      rd.data = irq_en_q;
    else if (ar_addr == `PMX_OFF_CHIP_CFG)
      rd.data = chip_cfg_q;
    else if (ar_addr == `PMX_OFF_STRAP)
      rd.data = strap_value[0] | strap_value[2] | strap_value[3];
    else if (ar_addr == `PMX_OFF_ISTAT)
      rd.data = istat_q;
    else if (ar_addr == `PMX_OFF_IMASK)
      rd.data = imask_q;
    else
      rd.resp = `PMX_RESP_SLVERR;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `PMX_RST_WORD;
      s_axi_rresp <= `PMX_RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd.data;
      s_axi_rresp <= rd.resp;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // pmx_top

/* File: pmx_top_tb.sv */
module pmx_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, irq_request;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, nmi_n, irq;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0][31:0] pad_in, pad_out, pad_drive_n, periph_out, periph_oe, periph_in, strap_value;
  logic [3:0][31:0] board_pads = {32'hFFFF_FF7F, 32'hFFFF_BFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
  logic power_on_reset_in_n = 1, board_hr_n = 1, clock_output_pin, device_reset_n;
  logic hard_reset_io_in, hard_reset_io_out, hard_reset_io_oe_n;
  int fail_count = 0, num_checks = 0;
  always #12.5 aclk = ~aclk;
  pmx_top i_pmx_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out, .pad_drive_n, .periph_out, .periph_oe,
    .periph_in, .clock_output_pin, .irq_request, .nmi_n, .strap_value, .power_on_reset_in_n,
    .hard_reset_io_in, .hard_reset_io_out, .hard_reset_io_oe_n, .device_reset_n, .irq);
  pmx_board i_pmx_board (.aclk, .board_pads, .board_hr_n, .pad_out, .pad_drive_n,
    .hard_reset_io_out, .hard_reset_io_oe_n, .pad_in, .periph_out, .periph_oe,
    .clock_output_pin, .hard_reset_io_in);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(n, e, s_axi_rdata);
    @(posedge aclk);
  endtask
  task automatic t_gpo;
    wr(8'h40, 32'h1);
    wr(8'h10, 32'h1);
    wr(8'h20, 32'h0);
    cyc(6);
    chk("output drive", 32'hFFFF_FFFE, pad_drive_n[0]);
    chk("output irq off", 32'h0, irq_request);
    wr(8'h20, 32'h1);
    chk("output value", 32'h1, pad_out[0]);
    wr(8'h10, 32'h0);
    wr(8'h40, 32'h80);
  endtask
  task automatic t_irq;
    wr(8'h50, 32'h80);
    board_pads[0][7] <= 1'b0;
    cyc(6);
    chk("irq req", 32'h80, irq_request);
    chk("irq out", 32'h1, {31'h0, irq});
    rd("status", 8'h4C, 32'h80);
    rd("status clr", 8'h4C, 32'h0);
    wr(8'h50, 32'h0);
    board_pads[0][18] <= 1'b0;
    cyc(6);
    chk("irq masked", 32'h0, {31'h0, irq});
    chk("nmi level", 32'h0, {31'h0, nmi_n});
    rd("nmi status", 8'h4C, 32'h0004_0000);
    wr(8'h00, 32'h0002_1080);
    cyc(4);
    chk("irq owner off", 32'h0, irq_request);
    @(negedge aclk);
    chk("primary", {31'h0, periph_out[0][12]}, {31'h0, pad_out[0][12]});
    chk("primary drv", 32'h0, {31'h0, pad_drive_n[0][12]});
    chk("primary in", {31'h0, periph_out[0][12]}, {31'h0, periph_in[0][12]});
    cyc(1);
    wr(8'h44, 32'h1);
    @(negedge aclk);
    chk("alt clock", {31'h0, clock_output_pin}, {31'h0, pad_out[0][17]});
    chk("alt no primary", 32'h0, {31'h0, periph_in[0][17]});
    cyc(1);
    wr(8'h0C, 32'h8);
    wr(8'h44, 32'h3);
    @(negedge aclk);
    chk("alt clock d", {31'h0, clock_output_pin}, {31'h0, pad_out[3][3]});
    chk("alt d no primary", 32'h0, {31'h0, periph_in[3][3]});
    cyc(1);
  endtask
  task automatic t_rd_hold;
    s_axi_araddr <= 32'h0000_0044;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    cyc(3);
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("late read", 32'h3, s_axi_rdata);
    @(posedge aclk);
  endtask
  task automatic t_por;
    power_on_reset_in_n <= 1'b0;
    cyc(6);
    chk("por hold", 32'h0, {31'h0, device_reset_n});
    chk("hr drive", 32'h0, {31'h0, hard_reset_io_oe_n});
    chk("hr out", 32'h0, {31'h0, hard_reset_io_out});
    power_on_reset_in_n <= 1'b1;
    cyc(8);
    rd("owner clr", 8'h00, 32'h0);
    rd("strap", 8'h48, 32'h0001_8108);
    board_pads[3] <= 32'h0;
    board_hr_n <= 1'b0;
    cyc(6);
    chk("hr reset", 32'h0, {31'h0, device_reset_n});
    board_hr_n <= 1'b1;
    cyc(8);
    rd("strap kept", 8'h48, 32'h0001_8108);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    cyc(6);
    aresetn <= 1'b1;
    cyc(1);
    rd("dir idle", 8'h18, 32'h0);
    chk("read resp", 32'h0, {30'h0, rsp});
    rd("strap idle", 8'h48, 32'h0);
    rd("input level", 8'h30, 32'h3FFB_FFFF);
    chk("input float", 32'hFFFF_FFFF, pad_drive_n[0]);
    wr(8'h30, 32'hFFFF_FFFF);
    chk("ro write", 32'h2, {30'h0, rsp});
    rd("unmapped", 8'h60, 32'h0);
    chk("unmapped resp", 32'h2, {30'h0, rsp});
    wr(8'h04, 32'hFFFF_FFFF);
    chk("write resp", 32'h0, {30'h0, rsp});
    rd("owner b", 8'h04, 32'h0000_7FFF);
    t_gpo;
    t_irq;
    t_rd_hold;
    t_por;
    end_of_test;
  end
  initial
  begin
    cyc(5000);
    fail_count++;
    end_of_test;
  end
endmodule // pmx_top_tb
